// file: src/rcs_byte_if.sv
// Byte stream with valid and ready between the block's own modules.
`timescale 1ns/1ps
`default_nettype none
interface rcs_byte_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : rcs_byte_if
`default_nettype wire

// file: src/rcs_cfg.svh
// Character codes, status bytes and sizes of the reader command block.
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH

`define RCS_CH_QUERY     8'h21
`define RCS_CH_SCAN      8'h63
`define RCS_CH_STOP      8'h53
`define RCS_CH_DOT       8'h2e
`define RCS_CH_UNKNOWN   8'h3f
`define RCS_CH_COLLIDE   8'h43
`define RCS_CH_FAIL      8'h46
`define RCS_CH_NOCARD    8'h4e
`define RCS_CH_MODE      8'h4f
`define RCS_CH_RANGE     8'h52
`define RCS_CH_AUTH      8'h58
`define RCS_CH_VALFMT    8'h49
`define RCS_KTC_UPLOADED 8'h00
`define RCS_KTC_UP_ERR   8'h01
`define RCS_KTC_OTHER    8'h02
`define RCS_KTC_AWARE    8'hff
`define RCS_BYTE_W       8
`define RCS_FIFO_DEPTH   32
`define RCS_SYNC_STAGES  3

`endif

// file: src/rcs_fifo.sv
// Answer FIFO with a registered output stage toward the serial transmitter.
`timescale 1ns/1ps
`default_nettype none
module rcs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   rcs_byte_if.snk               in_port,
   output var  logic             out_valid,
   output var  logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 count;
      logic                        ovalid;
      logic [WIDTH-1:0]            odata;
   } rcs_fifo_t;

   rcs_fifo_t s_q;
   rcs_fifo_t s_d;
   logic      push;
   logic      pop;

   // Depth must be a power of two so the pointers wrap by themselves.
   assign in_port.ready = (s_q.count != (AW+1)'(DEPTH));

   always_comb begin
      s_d  = s_q;
      push = in_port.valid && in_port.ready;
      pop  = (s_q.count != '0) && (!s_q.ovalid || out_ready);
      if (push) begin
         s_d.mem[s_q.wr] = in_port.data;
         s_d.wr = s_q.wr + AW'(1);
      end
      if (pop) begin
         s_d.odata  = s_q.mem[s_q.rd];
         s_d.ovalid = 1'b1;
         s_d.rd     = s_q.rd + AW'(1);
      end else if (out_ready) begin
         s_d.ovalid = 1'b0;
      end
      s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign out_valid = s_q.ovalid;
   assign out_data  = s_q.odata;

   a_fifo_bound : assert property (@(posedge clock) disable iff (sys_rst)
      s_q.count <= (AW+1)'(DEPTH))
      else $error("Answer FIFO count went past its depth.");
endmodule : rcs_fifo
`default_nettype wire

// file: src/rcs_main.sv
// Host command interpreter with status query and repeating card scan.
//
// Overview of operation
// RULE1 - Every command gets an answer unless exempt.
// RULE2 - Green lamp on success, red on error.
// RULE3 - Card errors: C, N, X, value code.
// RULE4 - Command errors: ?, F, O, R.
// RULE5 - Status query answers ! while scanning; the code does so only in a noisy text scan, elsewhere the ! stops the scan.
// RULE6 - Status query reports key upload byte.
// RULE7 - Status query answers F when idle.
// RULE8 - No answer while key upload runs.
// RULE9 - Scan status query only in ASCII.
// RULE10 - Scan repeats while cards remain present.
// RULE11 - Any character stops scan, reply S.
// RULE12 - Noisy ASCII scan stops only on period.
// RULE13 - Many-cards flag reports several same-type cards.
// RULE14 - Auto-start flag enters scan in ASCII.
// RULE15 - Binary scan reports N without card.
// RULE16 - Scan works fully in binary mode.
// RULE17 - Mixed card types, length by type.
// RULE18 - Serials plain; encryption after login only.
// RULE19 - Host avoids binary scan on shared bus.
// RULE20 - Abort character is never run as command.
`timescale 1ns/1ps
`default_nettype none
`include "rcs_cfg.svh"
module rcs_main #(
   parameter int BYTE_W = `RCS_BYTE_W,
   parameter int DEPTH  = `RCS_FIFO_DEPTH
) (
   input  wire logic              clock,
   input  wire logic              sys_rst,
   input  wire logic              rx_valid,
   input  wire logic [BYTE_W-1:0] rx_data,
   output var  logic              rx_ready,
   input  wire logic              ascii_mode,
   input  wire logic              multi_card_flag,
   input  wire logic              auto_start_flag,
   input  wire logic              noisy_flag,
   input  wire logic              login_ok,
   input  wire logic              card_in_field_pin,
   input  wire logic              card_valid,
   input  wire logic [BYTE_W-1:0] card_data,
   input  wire logic              card_none,
   output var  logic              card_ready,
   output var  logic              scan_run,
   output var  logic              scan_multi,
   output var  logic              cmd_valid,
   output var  logic [BYTE_W-1:0] cmd_data,
   input  wire logic              exec_done,
   input  wire rcs_pkg::rcs_err_t exec_err,
   input  wire logic [BYTE_W-1:0] exec_ans,
   input  wire logic              exec_quiet,
   input  wire logic              ktc_prepare_active,
   input  wire logic              ktc_uploading,
   input  wire rcs_pkg::rcs_ktc_t ktc_result,
   output var  logic              tx_valid,
   output var  logic [BYTE_W-1:0] tx_data,
   input  wire logic              tx_ready,
   output var  logic              led_green,
   output var  logic              led_red,
   output var  logic              crypt_en
);
   import rcs_pkg::*;

   // Error kind to the single answer character.
   function automatic logic [7:0] err_char(input rcs_err_t e);
      case (e)
         err_collision: err_char = `RCS_CH_COLLIDE; // RULE3
         err_no_card:   err_char = `RCS_CH_NOCARD; // RULE3
         err_auth:      err_char = `RCS_CH_AUTH; // RULE3
         err_value_fmt: err_char = `RCS_CH_VALFMT; // RULE3
         err_unknown:   err_char = `RCS_CH_UNKNOWN; // RULE4
         err_mode:      err_char = `RCS_CH_MODE; // RULE4
         err_range:     err_char = `RCS_CH_RANGE; // RULE4
         default:       err_char = `RCS_CH_FAIL; // RULE4
      endcase
   endfunction : err_char

   function automatic logic [7:0] ktc_byte(input rcs_ktc_t k);
      case (k)
         ktc_uploaded:   ktc_byte = `RCS_KTC_UPLOADED;
         ktc_upload_err: ktc_byte = `RCS_KTC_UP_ERR;
         ktc_other_card: ktc_byte = `RCS_KTC_OTHER;
         default:        ktc_byte = `RCS_KTC_AWARE;
      endcase
   endfunction : ktc_byte

   rcs_main_t s_q;
   rcs_main_t s_d;
   logic      field_present;
   logic      rx_fire;
   logic      card_fire;
   logic      none_fire;
   logic      noisy_scan;
   logic      is_abort;
   logic      free;

   rcs_byte_if #(.W(BYTE_W)) answer ();

   rcs_sync u_field_sync (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .pin_in    (card_in_field_pin),
      .level_out (field_present)
   );

   // The FIFO lets a burst of serial numbers ride out a slow host link;
   // once it fills, the scan simply stops taking card bytes.
   rcs_fifo #(
      .WIDTH (BYTE_W),
      .DEPTH (DEPTH)
   ) u_answer_fifo (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .in_port   (answer),
      .out_valid (tx_valid),
      .out_data  (tx_data),
      .out_ready (tx_ready)
   );

   assign answer.valid = s_q.push_valid;
   assign answer.data  = s_q.push_data;

   always_comb begin
      s_d        = s_q;
      rx_fire    = rx_valid && s_q.rx_ready;
      card_fire  = card_valid && s_q.card_ready;
      none_fire  = card_none && s_q.card_ready;
      noisy_scan = noisy_flag && ascii_mode; // RULE12 RULE16
      is_abort   = !noisy_scan || (rx_data == `RCS_CH_DOT); // RULE12
      s_d.cmd_valid = 1'b0;
      if (s_q.push_valid && answer.ready) begin
         s_d.push_valid = 1'b0;
      end
      case (s_q.state)
         st_idle: begin
            if (rx_fire) begin
               if (rx_data == `RCS_CH_QUERY) begin
                  if (!ascii_mode) begin
                     // Binary mode has no status query.
                     s_d.push_valid = 1'b1; // RULE9
                     s_d.push_data  = `RCS_CH_UNKNOWN; // RULE9
                     s_d.led_green  = 1'b0;
                     s_d.led_red    = 1'b1;
                  end else if (ktc_uploading) begin
                     s_d.push_valid = 1'b0; // RULE8
                  end else if (ktc_prepare_active) begin
                     s_d.push_valid = 1'b1; // RULE6
                     s_d.push_data  = ktc_byte(ktc_result); // RULE6
                  end else begin
                     s_d.push_valid = 1'b1; // RULE7
                     s_d.push_data  = `RCS_CH_FAIL; // RULE7
                  end
               end else if (rx_data == `RCS_CH_SCAN) begin
                  s_d.state = st_scan; // RULE16
               end else begin
                  s_d.cmd_valid = 1'b1;
                  s_d.cmd_data  = rx_data;
                  s_d.state     = st_exec;
               end
            end else if (auto_start_flag && ascii_mode && !s_q.auto_done) begin
               s_d.state     = st_scan; // RULE14
               s_d.auto_done = 1'b1;
            end
         end
         st_exec: begin
            if (exec_done) begin
               s_d.state = st_idle;
               s_d.led_green = (exec_err == err_none); // RULE2
               s_d.led_red   = (exec_err != err_none); // RULE2
               if (!exec_quiet) begin
                  s_d.push_valid = 1'b1; // RULE1
                  s_d.push_data  = (exec_err == err_none) ?
                                   exec_ans : err_char(exec_err); // RULE3 RULE4
               end
            end
         end
         st_scan: begin
            // Bytes here are stop requests or status queries; a noisy text scan drops any other byte.
            if (rx_fire) begin
               if (is_abort) begin
                  s_d.state      = st_idle; // RULE20
                  s_d.push_valid = 1'b1; // RULE11
                  s_d.push_data  = `RCS_CH_STOP; // RULE11
               end else if (rx_data == `RCS_CH_QUERY) begin
                  s_d.push_valid = 1'b1; // RULE5
                  s_d.push_data  = `RCS_CH_QUERY; // RULE5
               end
            end else if (card_fire) begin
               // The engine ends each serial at its type's length.
               s_d.push_valid = 1'b1; // RULE10 RULE17
               s_d.push_data  = card_data; // RULE18
            end else if (none_fire && !ascii_mode) begin
               s_d.push_valid = 1'b1; // RULE15
               s_d.push_data  = `RCS_CH_NOCARD; // RULE15
            end
            s_d.led_green = field_present;
            s_d.led_red   = 1'b0;
         end
         default: begin
            s_d.state = st_idle;
         end
      endcase
      // Ready flags are registered, so they look at the next state.
      free         = !s_d.push_valid;
      s_d.turn     = !s_q.turn;
      s_d.rx_ready = 1'b0;
      s_d.card_ready = 1'b0;
      if (s_d.state == st_idle) begin
         s_d.rx_ready = free && !s_d.cmd_valid;
      end else if (s_d.state == st_scan) begin
         // Taking turns keeps a stop request from racing a card byte.
         s_d.rx_ready   = free && s_q.turn;
         s_d.card_ready = free && !s_q.turn;
      end
      s_d.scan_multi = multi_card_flag && (s_d.state == st_scan); // RULE13
      s_d.crypt_en   = login_ok && (s_d.state != st_scan); // RULE18
      // A flop of its own keeps the scan output free of decode glitches.
      s_d.scan_run   = (s_d.state == st_scan); // RULE10
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rx_ready   = s_q.rx_ready;
   assign card_ready = s_q.card_ready;
   assign scan_run   = s_q.scan_run;
   assign scan_multi = s_q.scan_multi;
   assign cmd_valid  = s_q.cmd_valid;
   assign cmd_data   = s_q.cmd_data;
   assign led_green  = s_q.led_green;
   assign led_red    = s_q.led_red;
   assign crypt_en   = s_q.crypt_en;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   a_scan_stop : assert property ( // RULE11
      s_q.state == st_scan && rx_fire && !noisy_scan
      |=> s_q.push_valid && s_q.push_data == `RCS_CH_STOP
          && s_q.state == st_idle)
      else $error("Scan abort did not answer S and stop.");

   a_noisy_hold : assert property ( // RULE12
      s_q.state == st_scan && rx_fire && noisy_scan
      && rx_data != `RCS_CH_DOT |=> s_q.state == st_scan)
      else $error("Noisy scan stopped on a non-period byte.");

   a_query_scan : assert property ( // RULE5
      s_q.state == st_scan && rx_fire && noisy_scan
      && rx_data == `RCS_CH_QUERY
      |=> s_q.push_valid && s_q.push_data == `RCS_CH_QUERY)
      else $error("Status query during scan did not answer !.");

   a_upload_quiet : assert property ( // RULE8
      s_q.state == st_idle && rx_fire && ascii_mode && ktc_uploading
      && rx_data == `RCS_CH_QUERY && !s_q.push_valid |=> !s_q.push_valid)
      else $error("Answer sent while key upload in progress.");

   a_query_off : assert property ( // RULE7
      s_q.state == st_idle && rx_fire && ascii_mode && !ktc_uploading
      && !ktc_prepare_active && rx_data == `RCS_CH_QUERY
      |=> s_q.push_valid && s_q.push_data == `RCS_CH_FAIL)
      else $error("Idle status query did not answer F.");

   a_bin_query : assert property ( // RULE9
      s_q.state == st_idle && rx_fire && !ascii_mode
      && rx_data == `RCS_CH_QUERY
      |=> s_q.push_data == `RCS_CH_UNKNOWN && s_q.led_red)
      else $error("Binary status query was not refused.");

   a_none_bin : assert property ( // RULE15
      s_q.state == st_scan && !rx_fire && !card_fire && none_fire
      && !ascii_mode |=> s_q.push_valid
      && s_q.push_data == `RCS_CH_NOCARD)
      else $error("Binary scan did not report N on empty field.");

   a_no_cmd_scan : assert property ( // RULE20
      s_q.state == st_scan |=> !s_q.cmd_valid)
      else $error("Byte forwarded as command during scan.");

   a_led_err : assert property ( // RULE2
      s_q.state == st_exec && exec_done && exec_err != err_none
      |=> s_q.led_red && !s_q.led_green && s_q.state == st_idle)
      else $error("Failed command did not light red lamp.");

   a_plain_scan : assert property ( // RULE18
      s_q.state == st_scan |-> !s_q.crypt_en)
      else $error("Encryption active during serial scan.");

   a_ready_apart : assert property ( // RULE20
      !(s_q.rx_ready && s_q.card_ready))
      else $error("Host byte and card byte were offered together.");

   a_card_echo : assert property ( // RULE10
      s_q.state == st_scan && !rx_fire && card_fire
      |=> s_q.push_valid && s_q.push_data == $past(card_data))
      else $error("Taken serial byte was not queued.");

   a_text_none : assert property ( // RULE15
      s_q.state == st_scan && !rx_fire && !card_fire && none_fire
      && ascii_mode |=> !s_q.push_valid)
      else $error("Text scan answered an empty field.");

   a_auto_enter : assert property ( // RULE14
      s_q.state == st_idle && !rx_fire && auto_start_flag && ascii_mode
      && !s_q.auto_done |=> s_q.state == st_scan && s_q.auto_done)
      else $error("Auto start did not enter the scan.");

   a_exec_answer : assert property ( // RULE1
      s_q.state == st_exec && exec_done && !exec_quiet
      |=> s_q.push_valid && s_q.state == st_idle)
      else $error("Finished command queued no answer.");

   a_led_ok : assert property ( // RULE2
      s_q.state == st_exec && exec_done && exec_err == err_none
      |=> s_q.led_green && !s_q.led_red)
      else $error("Successful command did not light green lamp.");

   a_err_collide : assert property ( // RULE3
      s_q.state == st_exec && exec_done && !exec_quiet
      && exec_err == err_collision |=> s_q.push_data == `RCS_CH_COLLIDE)
      else $error("Collision error did not answer C.");

   a_err_unknown : assert property ( // RULE4
      s_q.state == st_exec && exec_done && !exec_quiet
      && exec_err == err_unknown |=> s_q.push_data == `RCS_CH_UNKNOWN)
      else $error("Unknown command did not answer question mark.");

   a_cmd_forward : assert property ( // RULE1
      s_q.state == st_idle && rx_fire && rx_data != `RCS_CH_QUERY
      && rx_data != `RCS_CH_SCAN |=> s_q.cmd_valid && s_q.state == st_exec
      && s_q.cmd_data == $past(rx_data))
      else $error("Command byte was not forwarded to the executor.");

   a_ktc_answer : assert property ( // RULE6
      s_q.state == st_idle && rx_fire && ascii_mode && !ktc_uploading
      && ktc_prepare_active && rx_data == `RCS_CH_QUERY
      |=> s_q.push_valid && s_q.push_data != `RCS_CH_FAIL)
      else $error("Key upload status was not answered.");

   a_multi_scan : assert property ( // RULE13
      s_q.scan_multi |-> s_q.state == st_scan)
      else $error("Many-cards reporting active outside the scan.");
endmodule : rcs_main
`default_nettype wire

// file: src/rcs_pkg.sv
// Types shared by the reader command block.
`default_nettype none
package rcs_pkg;
   typedef enum logic [1:0] {st_idle, st_exec, st_scan} rcs_state_t;

   typedef enum logic [3:0] {
      err_none, err_collision, err_no_card, err_auth, err_value_fmt,
      err_unknown, err_general, err_mode, err_range
   } rcs_err_t;

   typedef enum logic [1:0] {
      ktc_uploaded, ktc_upload_err, ktc_other_card, ktc_aware
   } rcs_ktc_t;

   typedef struct packed {
      rcs_state_t state;
      logic       push_valid;
      logic [7:0] push_data;
      logic       rx_ready;
      logic       card_ready;
      logic       turn;
      logic       cmd_valid;
      logic [7:0] cmd_data;
      logic       led_green;
      logic       led_red;
      logic       scan_multi;
      logic       crypt_en;
      logic       auto_done;
      logic       scan_run;
   } rcs_main_t;
endpackage : rcs_pkg
`default_nettype wire

// file: src/rcs_sync.sv
// Three-stage synchroniser; the output follows once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module rcs_sync (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic pin_in,
   output var  logic level_out
);
   typedef struct packed {
      logic [2:0] stage;
      logic       level;
   } rcs_sync_t;

   rcs_sync_t s_q;
   rcs_sync_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.stage = {s_q.stage[1:0], pin_in};
      if (s_q.stage[1] == s_q.stage[2]) begin
         s_d.level = s_q.stage[2];
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level_out = s_q.level;
endmodule : rcs_sync
`default_nettype wire

// file: verif/rcs_host.sv
// Host model: sends command bytes and paces the answer stream.
`timescale 1ns/1ps
`default_nettype none
module rcs_host (
   input  wire logic       clock,
   input  wire logic       rx_ready,
   output var  logic       rx_valid,
   output var  logic [7:0] rx_data,
   output var  logic       tx_ready,
   output var  logic       stuck
);
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      tx_ready = 1'b1;
      stuck    = 1'b0;
   end

   // Random back-pressure, so answers must wait in the FIFO.
   always @(posedge clock) tx_ready <= ($urandom % 4) != 0;

   // Any byte ends a plain scan, a period a noisy text scan. The link is
   // point to point, so a binary scan never takes over a shared bus.
   task automatic send(input logic [7:0] b);
      int n = 0;
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data  <= b;
      do begin
         @(posedge clock);
         n++;
      end while (!rx_ready && n < 400);
      stuck    <= !rx_ready;
      rx_valid <= 1'b0;
      // A released line must not keep showing the last byte.
      rx_data  <= ~b;
   endtask : send
endmodule : rcs_host
`default_nettype wire

// file: verif/rcs_main_tb_top.sv
// Self-checking bench for the reader command interpreter.
`timescale 1ns/1ps
`default_nettype none
module rcs_main_tb_top;
   import rcs_pkg::*;
   logic       clock = 1'b0, sys_rst = 1'b1, ascii_mode = 1'b1;
   logic       multi_card_flag = 1'b0, auto_start_flag = 1'b0;
   logic       noisy_flag = 1'b0, login_ok = 1'b0, card_in_field_pin = 1'b0;
   logic       card_valid = 1'b0, card_none = 1'b0, exec_done = 1'b0;
   logic       exec_quiet = 1'b0, ktc_prepare_active = 1'b0;
   logic       ktc_uploading = 1'b0;
   logic [7:0] card_data = 8'h00, exec_ans = 8'h00, lastc = 8'h00, b, r;
   rcs_err_t   exec_err = err_none;
   rcs_ktc_t   ktc_result = ktc_uploaded;
   logic       rx_valid, rx_ready, card_ready, scan_run, scan_multi;
   logic       cmd_valid, tx_valid, tx_ready, led_green, led_red;
   logic       crypt_en, stuck;
   logic [7:0] rx_data, cmd_data, tx_data;
   logic [7:0] expq[$];
   logic [7:0] errch [0:8] = '{8'h00, 8'h43, 8'h4e, 8'h58, 8'h49,
                               8'h3f, 8'h46, 8'h4f, 8'h52};
   logic [7:0] ktcb [0:3] = '{8'h00, 8'h01, 8'h02, 8'hff};
   int         n_mismatch = 0, checked = 0, ncmd = 0, ecnt = 0, i;

   rcs_main rcs_main_inst (
      .clock, .sys_rst, .rx_valid, .rx_data, .rx_ready, .ascii_mode,
      .multi_card_flag, .auto_start_flag, .noisy_flag, .login_ok,
      .card_in_field_pin, .card_valid, .card_data, .card_none, .card_ready,
      .scan_run, .scan_multi, .cmd_valid, .cmd_data, .exec_done, .exec_err,
      .exec_ans, .exec_quiet, .ktc_prepare_active, .ktc_uploading,
      .ktc_result, .tx_valid, .tx_data, .tx_ready, .led_green, .led_red,
      .crypt_en);
   rcs_host rcs_host_inst (
      .clock, .rx_ready, .rx_valid, .rx_data, .tx_ready, .stuck);

   always #10 clock = ~clock;

   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   task automatic give_up;
      n_mismatch++;
      $display("Error wait expected handshake seen timeout");
      summarize();
   endtask : give_up

   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   always @(posedge clock) if (stuck) give_up();

   // Executor stand-in: finishes each forwarded byte three cycles later.
   always @(posedge clock) begin
      if (cmd_valid) ncmd++;
      if (cmd_valid) chk("cmd_data", cmd_data, lastc);
      exec_done <= !cmd_valid && ecnt == 1;
      ecnt <= cmd_valid ? 3 : (ecnt != 0 ? ecnt - 1 : 0);
   end

   // Answer watcher: every byte taken must be the oldest expected one.
   always @(posedge clock) begin
      if (!sys_rst && tx_valid && tx_ready) begin
         if (expq.size() == 0) chk("tx_extra", 8'h01, 8'h00);
         else chk("tx_data", tx_data, expq.pop_front());
      end
   end

   task automatic card(input logic none, input logic [7:0] d);
      int n = 0;
      @(posedge clock);
      card_valid <= !none;
      card_none  <= none;
      card_data  <= d;
      do begin
         @(posedge clock);
         n++;
      end while (!card_ready && n < 400);
      if (!card_ready) give_up();
      card_valid <= 1'b0;
      card_none  <= 1'b0;
      card_data  <= ~d;
   endtask : card

   // The idle tail lets a stray extra answer show up before moving on.
   task automatic drain;
      int n = 0;
      while (expq.size() != 0 && n < 500) begin
         @(posedge clock);
         n++;
      end
      if (expq.size() != 0) give_up();
      repeat (12) @(posedge clock);
   endtask : drain

   task automatic do_reset;
      sys_rst <= 1'b1;
      repeat (6) @(posedge clock);
      chk("rst_tx", 8'(tx_valid), 8'h00);
      chk("rst_lamps", 8'({led_green, led_red}), 8'h00);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : do_reset

   task automatic cmd(input logic [7:0] c, input int e, input logic q);
      logic [7:0] a = 8'($urandom);
      exec_err   <= rcs_err_t'(e);
      exec_quiet <= q;
      exec_ans   <= a;
      lastc      <= c;
      if (!q) expq.push_back(e == 0 ? a : errch[e]);
      rcs_host_inst.send(c);
      drain();
      if (!q) chk("led_red", 8'(led_red), 8'(e != 0));
      if (!q) chk("led_green", 8'(led_green), 8'(e == 0));
   endtask : cmd

   task automatic stop_scan(input logic [7:0] c);
      expq.push_back(8'h53);
      rcs_host_inst.send(c);
      drain();
      chk("scan_stop", 8'(scan_run), 8'h00);
   endtask : stop_scan

   initial begin
      void'($urandom(32'hfe336010));
      do_reset();
      $display("test reset done");
      expq.push_back(8'h46);
      rcs_host_inst.send(8'h21);
      drain();
      // The fifth pass uploads keys: the query is taken but not answered.
      for (i = 0; i < 5; i++) begin
         ktc_prepare_active <= i < 4 || 1'($urandom);
         ktc_uploading <= i == 4;
         ktc_result <= rcs_ktc_t'(i % 4);
         if (i < 4) expq.push_back(ktcb[i]);
         rcs_host_inst.send(8'h21);
         drain();
      end
      ktc_uploading <= 1'b0;
      ktc_prepare_active <= 1'b0;
      ascii_mode <= 1'b0;
      expq.push_back(8'h3f);
      rcs_host_inst.send(8'h21);
      drain();
      chk("query_bin_red", 8'(led_red), 8'h01);
      ascii_mode <= 1'b1;
      $display("test query done");
      // The last pass is a quiet command that must not answer.
      for (i = 0; i < 10; i++) cmd(8'h72, i % 9, i == 9);
      $display("test executor done");
      r = 8'($urandom);
      login_ok <= r[0];
      multi_card_flag <= r[1];
      repeat (3) @(posedge clock);
      chk("crypt_idle", 8'(crypt_en), 8'(r[0]));
      i = ncmd;
      rcs_host_inst.send(8'h63);
      repeat (3) @(posedge clock);
      chk("scan_run", 8'(scan_run), 8'h01);
      chk("scan_multi", 8'(scan_multi), 8'(r[1]));
      chk("crypt_scan", 8'(crypt_en), 8'h00);
      // A random mix of card bytes and empty sweeps in text mode: only the empty sweeps must stay silent.
      repeat (5) begin
         b = 8'($urandom);
         if (!b[0]) expq.push_back(b);
         card(b[0], b);
      end
      card(1'b1, 8'h00);
      card_in_field_pin <= 1'b1;
      drain();
      chk("led_scan", 8'(led_green), 8'h01);
      card_in_field_pin <= r[2];
      stop_scan(8'h78);
      chk("abort_no_cmd", ncmd[7:0], i[7:0]);
      $display("test text scan done");
      noisy_flag <= 1'b1;
      multi_card_flag <= !r[1];
      rcs_host_inst.send(8'h63);
      expq.push_back(8'h21);
      rcs_host_inst.send(8'h21);
      rcs_host_inst.send(8'h78);
      drain();
      chk("noisy_hold", 8'(scan_run), 8'h01);
      chk("multi_off", 8'(scan_multi), 8'(!r[1]));
      stop_scan(8'h2e);
      $display("test noisy scan done");
      ascii_mode <= 1'b0;
      rcs_host_inst.send(8'h63);
      expq.push_back(8'h4e);
      card(1'b1, 8'h00);
      b = 8'($urandom);
      expq.push_back(b);
      card(1'b0, b);
      stop_scan(8'h78);
      $display("test binary scan done");
      ascii_mode <= 1'b1;
      noisy_flag <= 1'b0;
      auto_start_flag <= 1'b1;
      do_reset();
      chk("auto_scan", 8'(scan_run), 8'h01);
      stop_scan(8'h71);
      chk("auto_once", 8'(scan_run), 8'h00);
      $display("test auto start done");
      summarize();
   end
endmodule : rcs_main_tb_top
`default_nettype wire
